// [cond_eval.sv]
// condition-code evaluator for conditional execution
`timescale 1ns/100ps

module cond_eval
(
	input  wire logic [3:0] cond,
	input  wire logic [3:0] flags,
	output logic            pass
);

	logic n;
	logic z;
	logic c;
	logic v;
	logic base;

	assign n = flags[3];
	assign z = flags[2];
	assign c = flags[1];
	assign v = flags[0];

	// evaluate the base condition, then invert on the low bit; base code 7 always passes
	always_comb
	begin
		case (cond[3:1])
			3'h0:    base = z;
			3'h1:    base = c;
			3'h2:    base = n;
			3'h3:    base = v;
			3'h4:    base = c & ~z;
			3'h5:    base = (n == v);
			3'h6:    base = ~z & (n == v);
			default: base = 1'b1;
		endcase
		if (cond[3:1] == 3'h7)
			pass = 1'b1;
		else
			pass = base ^ cond[0];
	end

endmodule : cond_eval

// [exec_state.sv]
// execution-state part of the status word: split field, state bit, saturation flag
`timescale 1ns/100ps
`include "exec_state_defines.svh"

module exec_state
	import exec_state_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// condition flags from the flag view, for conditional execution
	input  wire logic [3:0]  cond_flags,
	// saturation event from the arithmetic unit
	input  wire logic        sat_event,
	// if-then instruction issue: 8-bit state (base condition + mask)
	input  wire logic        ifthen_issue,
	input  wire logic [7:0]  ifthen_value,
	// one instruction retires (or is skipped) in the stream
	input  wire logic        instr_step,
	// indirect branch, branch-with-link indirect, pop to program counter
	input  wire logic        branch_load,
	input  wire logic [31:0] branch_target,
	// exception entry and return
	input  wire logic        exc_entry,
	input  wire logic [31:0] exc_vector,
	input  wire logic        exc_return,
	input  wire logic [31:0] exc_stacked_psw,
	// multi-register transfer interrupted, with the next operand number
	input  wire logic        xfer_suspend,
	input  wire logic [3:0]  xfer_next_reg,
	input  wire logic        xfer_done,
	// special-register access from software
	input  wire logic        sr_write,
	input  wire logic [1:0]  sr_view,
	input  wire logic [31:0] sr_wdata,
	input  wire logic        sr_internal,
	output logic [31:0]      sr_rdata,
	// status to the pipeline
	output logic             exec_enable,
	output logic             in_ifthen,
	output logic             state_fault,
	output logic [3:0]       resume_reg,
	output logic             sat_flag,
	output logic             state_bit
);

	//------------------------------------------------------------
	// state
	//------------------------------------------------------------
	logic        sat_reg;
	logic        state_reg;
	logic [7:0]  exec_field_reg;
	field_mode_t mode_reg;
	logic        fault_reg;
	logic [31:0] psw_full;
	logic        cond_pass;
	logic [3:0]  cur_cond;
	logic        write_flags;

	// true for the views that carry the flag bits
	function automatic logic view_has_flags(input logic [1:0] view);
		view_has_flags = (view == `VIEW_FULL) || (view == `VIEW_FLAGS);
	endfunction : view_has_flags

	// true for the views that carry execution-state bits
	function automatic logic view_has_exec(input logic [1:0] view);
		view_has_exec = (view == `VIEW_FULL) || (view == `VIEW_EXEC);
	endfunction : view_has_exec

	assign write_flags = sr_write && view_has_flags(sr_view);

	//------------------------------------------------------------
	// saturation flag
	//------------------------------------------------------------
	// only a software write clears; a same-cycle event wins
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			sat_reg <= 1'b0;
		else if (sat_event)
			sat_reg <= 1'b1;
		else if (write_flags)
			sat_reg <= sr_wdata[`PSW_SAT_BIT];
	end

	//------------------------------------------------------------
	// instruction-set state bit
	//------------------------------------------------------------
	// entry, return and indirect branches reload it; software cannot
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			state_reg <= `STATE_BIT_RESET;
		else if (exc_entry)
			state_reg <= exc_vector[0];
		else if (exc_return)
			state_reg <= exc_stacked_psw[`PSW_STATE_BIT];
		else if (branch_load)
			state_reg <= branch_target[0];
	end

	// fault when an instruction is attempted with the bit clear
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			fault_reg <= 1'b0;
		else
			fault_reg <= instr_step && !state_reg && !exc_entry;
	end

	//------------------------------------------------------------
	// split execution-state field
	//------------------------------------------------------------
	// field bits [7:2] map to 15:10, bits [1:0] to 26:25
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			exec_field_reg <= `EXEC_FIELD_RESET;
			mode_reg       <= FIELD_IDLE;
		end
		else if (exc_entry)
		begin
			exec_field_reg <= `EXEC_FIELD_RESET;
			mode_reg       <= FIELD_IDLE;
		end
		else if (exc_return)
		begin
			// restore both halves from the stacked word
			exec_field_reg <= {exc_stacked_psw[`PSW_LO_MSB:`PSW_LO_LSB],
				exc_stacked_psw[`PSW_HI_MSB:`PSW_HI_LSB]};
			if (exc_stacked_psw[`PSW_LO_LSB +: 2] != 2'h0 ||
				exc_stacked_psw[`PSW_HI_MSB:`PSW_HI_LSB] != 2'h0)
				mode_reg <= FIELD_IFTHEN;
			else if (exc_stacked_psw[`PSW_RESUME_MSB:`PSW_RESUME_LSB] != 4'h0)
				mode_reg <= FIELD_RESUME;
			else
				mode_reg <= FIELD_IDLE;
		end
		else if (xfer_suspend)
		begin
			// next operand to 15:12, all other field bits zero
			exec_field_reg <= {xfer_next_reg, 4'h0};
			mode_reg       <= FIELD_RESUME;
		end
		else if (ifthen_issue)
		begin
			// field layout: [7:4] base condition, [3:0] mask
			exec_field_reg <= {ifthen_value[7:4], ifthen_value[3:0]};
			mode_reg       <= FIELD_IFTHEN;
		end
		else
		begin
			case (mode_reg)
				FIELD_IFTHEN:
				begin
					if (instr_step)
					begin
						if (exec_field_reg[2:0] == 3'h0)
						begin
							exec_field_reg <= `EXEC_FIELD_RESET;
							mode_reg       <= FIELD_IDLE;
						end
						else
							// shift mask; top bit feeds condition lsb
							exec_field_reg[4:0] <= {exec_field_reg[3:0], 1'b0};
					end
				end
				FIELD_RESUME:
				begin
					if (xfer_done)
					begin
						exec_field_reg <= `EXEC_FIELD_RESET;
						mode_reg       <= FIELD_IDLE;
					end
				end
				FIELD_IDLE:
				begin
					exec_field_reg <= `EXEC_FIELD_RESET;
				end
				default:
				begin
					exec_field_reg <= `EXEC_FIELD_RESET;
					mode_reg       <= FIELD_IDLE;
				end
			endcase
		end
	end

	//------------------------------------------------------------
	// conditional execution inside an if-then block
	//------------------------------------------------------------
	// the current condition is base with its lsb from the mask
	assign cur_cond = exec_field_reg[7:4];

	cond_eval u_cond_eval
	(
		.cond  (cur_cond),
		.flags (cond_flags),
		.pass  (cond_pass)
	);

	assign in_ifthen   = (mode_reg == FIELD_IFTHEN);
	assign exec_enable = state_reg && (!in_ifthen || cond_pass);

	//------------------------------------------------------------
	// full status word and software read-back
	//------------------------------------------------------------
	// force 26:25 to zero while the resume state is held
	always_comb
	begin
		psw_full = 32'h00000000;
		psw_full[`PSW_SAT_BIT]   = sat_reg;
		psw_full[`PSW_STATE_BIT] = state_reg;
		psw_full[`PSW_LO_MSB:`PSW_LO_LSB] = exec_field_reg[7:2];
		if (mode_reg == FIELD_RESUME)
			psw_full[`PSW_HI_MSB:`PSW_HI_LSB] = 2'h0;
		else
			psw_full[`PSW_HI_MSB:`PSW_HI_LSB] = exec_field_reg[1:0];
	end

	// software sees no execution-state bits; the stacking path does
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			sr_rdata <= 32'h00000000;
		else
		begin
			sr_rdata <= 32'h00000000;
			if (view_has_flags(sr_view))
				sr_rdata[`PSW_SAT_BIT] <= sat_reg;
			if (view_has_exec(sr_view) && sr_internal)
			begin
				sr_rdata[`PSW_HI_MSB:`PSW_STATE_BIT] <=
					psw_full[`PSW_HI_MSB:`PSW_STATE_BIT];
				sr_rdata[`PSW_LO_MSB:`PSW_LO_LSB] <=
					psw_full[`PSW_LO_MSB:`PSW_LO_LSB];
			end
			// software reads of exec bits stay zero
		end
	end

	assign state_fault = fault_reg;
	assign resume_reg  = (mode_reg == FIELD_RESUME) ?
		exec_field_reg[7:4] : 4'h0;
	assign sat_flag    = sat_reg;
	assign state_bit   = state_reg;

endmodule : exec_state

// [exec_state_checker.sv]
// port assertions for the execution-state block
`timescale 1ns/100ps

module exec_state_checker
(
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        sat_event,
	input wire logic        instr_step,
	input wire logic        branch_load,
	input wire logic [31:0] branch_target,
	input wire logic        exc_entry,
	input wire logic [31:0] exc_vector,
	input wire logic        exc_return,
	input wire logic [31:0] exc_stacked_psw,
	input wire logic        xfer_suspend,
	input wire logic [3:0]  xfer_next_reg,
	input wire logic        sr_write,
	input wire logic        sr_internal,
	input wire logic [31:0] sr_rdata,
	input wire logic        exec_enable,
	input wire logic        in_ifthen,
	input wire logic        state_fault,
	input wire logic [3:0]  resume_reg,
	input wire logic        sat_flag,
	input wire logic        state_bit
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	// saturation flag
	AST_SAT_HOLD: assert property (sat_flag && !sr_write |=> sat_flag)
		else $error("sat flag dropped");
	AST_SAT_SET: assert property (sat_event |=> sat_flag)
		else $error("sat flag not set");
	// state bit sources
	AST_BR_LOAD: assert property (branch_load && !exc_entry && !exc_return
		|=> state_bit == $past(branch_target[0])) else $error("branch load");
	AST_EXC_RET: assert property (exc_return && !exc_entry
		|=> state_bit == $past(exc_stacked_psw[24])) else $error("return load");
	AST_EXC_ENT: assert property (exc_entry |=> state_bit == $past(exc_vector[0])
		&& !in_ifthen && resume_reg == 4'h0) else $error("entry load");
	// fault with state bit clear
	AST_FAULT: assert property (instr_step && !state_bit && !exc_entry |=> state_fault)
		else $error("no fault");
	AST_NO_EXEC: assert property (!state_bit |-> !exec_enable)
		else $error("exec with bit clear");
	// software view and writes
	AST_SR_READ: assert property (!sr_internal
		|=> sr_rdata[26:24] == 3'h0 && sr_rdata[15:10] == 6'h00) else $error("exec bits read");
	AST_SW_WRITE: assert property (sr_write && !exc_entry && !exc_return && !branch_load
		|=> $stable(state_bit)) else $error("state bit written");
	// interrupted transfer
	AST_RESUME: assert property (xfer_suspend && !exc_entry && !exc_return
		|=> resume_reg == $past(xfer_next_reg)) else $error("resume reg");
endmodule : exec_state_checker

// [exec_state_defines.svh]
// bit positions, reset values and view codes of the execution-state block
`ifndef EXEC_STATE_DEFINES_SVH
`define EXEC_STATE_DEFINES_SVH

//------------------------------------------------------------
// field positions
//------------------------------------------------------------
`define PSW_SAT_BIT       27
`define PSW_STATE_BIT     24
`define PSW_HI_MSB        26
`define PSW_HI_LSB        25
`define PSW_LO_MSB        15
`define PSW_LO_LSB        10
`define PSW_RESUME_MSB    15
`define PSW_RESUME_LSB    12

//------------------------------------------------------------
// reset values
//------------------------------------------------------------
`define PSW_RESET         32'h01000000
`define EXEC_FIELD_RESET  8'h00
`define STATE_BIT_RESET   1'b1

//------------------------------------------------------------
// view select codes of a special-register access
//------------------------------------------------------------
`define VIEW_FULL         2'h0
`define VIEW_FLAGS        2'h1
`define VIEW_EXEC         2'h2
`define VIEW_OTHER        2'h3

`endif

// [exec_state_pkg.sv]
// types shared by the execution-state block
package exec_state_pkg;

	// what the split field currently holds
	typedef enum logic [1:0] {FIELD_IDLE, FIELD_IFTHEN, FIELD_RESUME} field_mode_t;

endpackage : exec_state_pkg

// [tb_top.sv]
// self-checking bench for the execution-state block
`timescale 1ns/100ps
`include "exec_state_defines.svh"

module tb_top;
	import exec_state_pkg::*;
	typedef struct packed {logic [1:0] kind; logic [31:0] data; logic exp;} row_t;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [3:0]  cond_flags, xfer_next_reg, resume_reg;
	logic [7:0]  ifthen_value;
	logic [1:0]  sr_view;
	logic [31:0] branch_target, exc_vector, exc_stacked_psw, sr_wdata, sr_rdata;
	logic        sat_event, ifthen_issue, instr_step, branch_load, exc_entry;
	logic        exc_return, xfer_suspend, xfer_done, sr_write, sr_internal;
	logic        exec_enable, in_ifthen, state_fault, sat_flag, state_bit;
	int          fails = 0;
	int          total_checks = 0;
	// kind 0 branch, 1 entry, 2 return
	row_t rows[6] = '{'{2'h0, 32'h00000100, 1'b0}, '{2'h0, 32'h00000003, 1'b1},
		'{2'h2, 32'h00000000, 1'b0}, '{2'h1, 32'h00000041, 1'b1},
		'{2'h2, 32'h01000000, 1'b1}, '{2'h1, 32'h00000040, 1'b0}};

	always #2 clk = ~clk;

	exec_state exec_state_i (.*);

	//----------------------------------------
	// helpers
	//----------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	// one edge, then drop all pulses
	task tick;
		@(posedge clk);
		#1;
		{sat_event, ifthen_issue, instr_step, branch_load, exc_entry} = '0;
		{exc_return, xfer_suspend, xfer_done, sr_write} = '0;
	endtask : tick
	task close_out;
		if (fails == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out

	// hang guard
	initial
	begin
		#100000;
		fails++;
		close_out();
	end

	//----------------------------------------
	// main sequence
	//----------------------------------------
	initial
	begin
		{cond_flags, xfer_next_reg, ifthen_value, sr_view, sr_internal} = '0;
		{branch_target, exc_vector, exc_stacked_psw, sr_wdata} = '0;
		repeat (6) tick();
		sys_rst = 1'b0;
		foreach (rows[i])
		begin
			branch_load = rows[i].kind == 2'h0;
			exc_entry = rows[i].kind == 2'h1;
			exc_return = rows[i].kind == 2'h2;
			{branch_target, exc_vector, exc_stacked_psw} = {3{rows[i].data}};
			tick();
			chk(state_bit, rows[i].exp);
			chk(exec_enable, rows[i].exp);
			instr_step = 1'b1;
			tick();
			chk(state_fault, !rows[i].exp);
		end
		// second reset with the state bit clear
		sys_rst = 1'b1;
		tick();
		chk({state_bit, sat_flag, exec_enable, in_ifthen}, 4'hA);
		sys_rst = 1'b0;
		// sticky flag, set beats a clearing write
		sat_event = 1'b1;
		tick();
		exc_entry = 1'b1;
		exc_vector = 32'h00000001;
		tick();
		chk(sat_flag, 1'b1);
		{sat_event, sr_write, sr_view, sr_wdata} = {2'h3, `VIEW_FULL, 32'h00000000};
		tick();
		chk(sat_flag, 1'b1);
		sr_write = 1'b1;
		tick();
		chk(sat_flag, 1'b0);
		chk(state_bit, 1'b1);
		chk(sr_rdata, 32'h08000000);
		// a write through a view without the flag leaves it set
		sat_event = 1'b1;
		tick();
		{sr_write, sr_view} = {1'b1, `VIEW_EXEC};
		tick();
		chk(sat_flag, 1'b1);
		// four-instruction block, inverse condition on the second only
		{cond_flags, ifthen_issue, ifthen_value} = {4'h4, 1'b1, 8'h09};
		tick();
		for (int k = 0; k < 4; k++)
		begin
			chk(in_ifthen, 1'b1);
			chk(exec_enable, k != 1);
			instr_step = 1'b1;
			tick();
		end
		chk(in_ifthen, 1'b0);
		// interrupted transfer seen through the stacking path
		{xfer_suspend, xfer_next_reg, sr_internal} = {1'b1, 4'hA, 1'b1};
		tick();
		chk(resume_reg, 4'hA);
		tick();
		chk(sr_rdata[26:25], 2'h0);
		chk(sr_rdata[15:12], 4'hA);
		{sr_internal, xfer_done} = 2'h1;
		tick();
		chk(resume_reg, 4'h0);
		chk(sr_rdata & 32'h0700FC00, 32'h0);
		// return restores an if-then state, entry clears it
		{exc_return, exc_stacked_psw} = {1'b1, 32'h03000000};
		tick();
		chk(in_ifthen, 1'b1);
		chk(state_bit, 1'b1);
		{exc_entry, exc_vector} = {1'b1, 32'h00000001};
		tick();
		chk(in_ifthen, 1'b0);
		close_out();
	end
endmodule : tb_top

bind exec_state exec_state_checker exec_state_checker_i (.*);
